/* File: csv_map.svh */
`ifndef CSV_MAP_SVH
`define CSV_MAP_SVH
// ****************************************
// register byte offsets
// ****************************************
`define CSV_OFF_INSTATE   12'h000
`define CSV_OFF_ECHO      12'h004
`define CSV_OFF_STATUS    12'h008
`define CSV_OFF_CTRL      12'h00C
`define CSV_OFF_CFG       12'h010
`define CSV_OFF_OUTARR    12'h014
`define CSV_OFF_RANGE     12'h018
`define CSV_OFF_IRQ_STAT  12'h01C
`define CSV_OFF_IRQ_MASK  12'h020
`define CSV_OFF_LATCH     12'h024
// ****************************************
// field layout
// ****************************************
`define CSV_NUM_OUT       4
`define CSV_NUM_RANGE     4
`define CSV_OUT_USED_MASK 32'h0000_000F
`define CSV_CFG_CNT_LSB   0
`define CSV_CFG_CNT_MSB   1
`define CSV_CFG_LATCH_BIT 2
`define CSV_CTRL_OC_CLR   0
`define CSV_ST_CFG_OK     0
`define CSV_ST_RSV_ERR    1
`define CSV_ST_GEN_ERR    2
`define CSV_ST_RNG_LSB    4
`define CSV_ST_OC_LSB     8
`define CSV_CHECK_CYCLES  4'h4
`define CSV_ZERO32        32'h0000_0000
`define CSV_SLVERR_DATA   32'hDEAD_BEEF
`endif

/* File: csv_pkg.sv */
package csv_pkg;
  typedef enum logic [1:0] {
    CSV_CFG_IDLE  = 2'b00,
    CSV_CFG_CHECK = 2'b01,
    CSV_CFG_DONE  = 2'b11
  } csv_cfg_state_t;
endpackage

/* File: csv_sync3.sv */
`timescale 1ns/1ps
// three-stage sampler; value changes once stages two and three agree
module csv_sync3 (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // pin side
  input  wire logic pin_in,
  // core side
  output logic      sample_out
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_out <= 1'b0;
    end else if (s2_reg == s3_reg) begin
      sample_out <= s3_reg;
    end
  end
endmodule

/* File: csv_range_check.sv */
`timescale 1ns/1ps
`include "csv_map.svh"
// flags each range whose selected counter lies beyond the configured count
module csv_range_check
  import csv_pkg::*;
(
  // range setup words: counter select per range, 2 bits each
  input  wire logic [7:0] range_setup_word,
  // number of configured counters, raw count; zero faults every range
  input  wire logic [1:0] counter_count,
  // per-range error
  output logic [3:0]      range_counter_assign_error
);
  always_comb begin
    for (int i = 0; i < `CSV_NUM_RANGE; i++) begin
      // counter index must be below the configured number of counters
      range_counter_assign_error[i] = ({1'b0, range_setup_word[2*i +: 2]} >= {1'b0, counter_count});
    end
  end
endmodule

/* File: csv_status.sv */
`timescale 1ns/1ps
`include "csv_map.svh"
// Behaviour
// - second counter phase/index bits show latest sample
// - echo shows every last commanded output state
// - one overcurrent flag per output channel
// - latched overcurrent held until latch clear
// - config_accepted set once the four-cycle check completes; no error rejects it
// - config_accepted zero after reset and while checking
// - reserved bit set rejects whole output array
// - clean array clears flag, processing resumes
// - composite_error is OR of all errors
// - flag range selecting unconfigured counter
// - assignment error ignores array, holds until clean
module csv_status
  import csv_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // encoder pins of the second counter
  input  wire logic        phase_a_pin,
  input  wire logic        phase_b_pin,
  input  wire logic        index_pin,
  // outputs commanded by the counter logic itself
  input  wire logic [3:0]  counter_out_cmd,
  input  wire logic [3:0]  counter_out_cmd_valid,
  // over-current sense per output channel
  input  wire logic [3:0]  overcurrent_pin,
  // driven outputs and interrupt
  output logic [3:0]       output_drive,
  output logic             irq
);
  // ****************************************
  // declarations
  // ****************************************
  logic              a_smp, b_smp, z_smp;
  logic [3:0]        oc_smp [0:0];
  logic [3:0]        oc_now;
  logic [2:0]        phase_a_sample_bit;
  logic [3:0]        echo_reg;
  logic [3:0]        output_overcurrent_flag;
  logic [2:0]        cfg_reg;
  logic              config_accepted;
  logic [3:0]        check_cnt_reg;
  csv_cfg_state_t    cfg_state_reg;
  logic              reserved_bits_error;
  logic [3:0]        range_counter_assign_error;
  logic [3:0]        rng_err_now;
  logic [7:0]        range_setup_word;
  logic [31:0]       outarr_reg;
  logic              composite_error;
  logic [3:0]        irq_stat_reg;
  logic [3:0]        irq_mask_reg;
  logic [3:0]        ev;
  logic              wr_acc, rd_acc;
  logic              addr_ok;
  logic              err_prev_reg;
  logic              oc_clr;
  // ****************************************
  // input sampling
  // ****************************************
  csv_sync3 u_sa (.core_clk(core_clk), .rst_n(rst_n), .pin_in(phase_a_pin), .sample_out(a_smp));
  csv_sync3 u_sb (.core_clk(core_clk), .rst_n(rst_n), .pin_in(phase_b_pin), .sample_out(b_smp));
  csv_sync3 u_sz (.core_clk(core_clk), .rst_n(rst_n), .pin_in(index_pin),   .sample_out(z_smp));
  genvar g;
  generate
    for (g = 0; g < `CSV_NUM_OUT; g++) begin : g_oc
      csv_sync3 u_so (.core_clk(core_clk), .rst_n(rst_n), .pin_in(overcurrent_pin[g]), .sample_out(oc_now[g]));
    end
  endgenerate
  assign oc_smp[0] = oc_now;
  assign phase_a_sample_bit = {z_smp, b_smp, a_smp};
  // ****************************************
  // apb decode
  // ****************************************
  // zero wait state: pready is high throughout every access phase
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  always_comb begin
    if (paddr == `CSV_OFF_INSTATE) addr_ok = 1'b1;
    else if (paddr == `CSV_OFF_ECHO) addr_ok = 1'b1;
    else if (paddr == `CSV_OFF_STATUS) addr_ok = 1'b1;
    else if (paddr == `CSV_OFF_CTRL) addr_ok = 1'b1;
    else if (paddr == `CSV_OFF_CFG) addr_ok = 1'b1;
    else if (paddr == `CSV_OFF_OUTARR) addr_ok = 1'b1;
    else if (paddr == `CSV_OFF_RANGE) addr_ok = 1'b1;
    else if (paddr == `CSV_OFF_IRQ_STAT) addr_ok = 1'b1;
    else if (paddr == `CSV_OFF_IRQ_MASK) addr_ok = 1'b1;
    else if (paddr == `CSV_OFF_LATCH) addr_ok = 1'b1;
    else addr_ok = 1'b0;
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
    end
  end
  // ****************************************
  // configuration array and check
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= 3'b000;
    end else if (wr_acc && pready && paddr == `CSV_OFF_CFG) begin
      cfg_reg <= pwdata[2:0];
    end
  end
  // a new config restarts the check, so a stale accept never shows
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_state_reg <= CSV_CFG_IDLE;
      check_cnt_reg <= 4'h0;
    end else if (wr_acc && pready && paddr == `CSV_OFF_CFG) begin
      cfg_state_reg <= CSV_CFG_CHECK;
      check_cnt_reg <= 4'h0;
    end else begin
      case (cfg_state_reg)
        CSV_CFG_CHECK: begin
          if (check_cnt_reg == `CSV_CHECK_CYCLES - 4'h1) begin
            cfg_state_reg <= CSV_CFG_DONE;
          end
          check_cnt_reg <= check_cnt_reg + 4'h1;
        end
        default: begin
          check_cnt_reg <= 4'h0;
        end
      endcase
    end
  end
  // config bits above the used field are dropped; the check accepts every config
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      config_accepted <= 1'b0;
    end else if (wr_acc && pready && paddr == `CSV_OFF_CFG) begin
      config_accepted <= 1'b0;
    end else if (cfg_state_reg == CSV_CFG_CHECK && check_cnt_reg == `CSV_CHECK_CYCLES - 4'h1) begin
      config_accepted <= 1'b1;
    end
  end
  // ****************************************
  // output array validation
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      range_setup_word <= 8'h00;
    end else if (wr_acc && pready && paddr == `CSV_OFF_RANGE) begin
      range_setup_word <= pwdata[7:0];
    end
  end
  csv_range_check u_rc (
    .range_setup_word          (range_setup_word),
    .counter_count             (cfg_reg[`CSV_CFG_CNT_MSB:`CSV_CFG_CNT_LSB]),
    .range_counter_assign_error(rng_err_now)
  );
  // flags are evaluated on each output array write and held until the next
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      outarr_reg <= `CSV_ZERO32;
      reserved_bits_error <= 1'b0;
      range_counter_assign_error <= 4'h0;
    end else if (wr_acc && pready && paddr == `CSV_OFF_OUTARR) begin
      reserved_bits_error <= |(pwdata & ~`CSV_OUT_USED_MASK);
      range_counter_assign_error <= rng_err_now;
      if (((pwdata & ~`CSV_OUT_USED_MASK) == `CSV_ZERO32) && rng_err_now == 4'h0) begin
        outarr_reg <= pwdata;
      end
    end
  end
  // echo takes the newer of program and counter commands
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      echo_reg <= 4'h0;
      output_drive <= 4'h0;
    end else begin
      for (int i = 0; i < `CSV_NUM_OUT; i++) begin
        if (counter_out_cmd_valid[i]) begin
          echo_reg[i] <= counter_out_cmd[i];
          output_drive[i] <= counter_out_cmd[i];
        end else if (wr_acc && pready && paddr == `CSV_OFF_OUTARR
                     && ((pwdata & ~`CSV_OUT_USED_MASK) == `CSV_ZERO32) && rng_err_now == 4'h0) begin
          echo_reg[i] <= pwdata[i];
          output_drive[i] <= pwdata[i];
        end
      end
    end
  end
  // ****************************************
  // overcurrent
  // ****************************************
  assign oc_clr = wr_acc && pready && paddr == `CSV_OFF_CTRL && pwdata[`CSV_CTRL_OC_CLR];
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      output_overcurrent_flag <= 4'h0;
    end else if (cfg_reg[`CSV_CFG_LATCH_BIT]) begin
      // live fault wins over clear so a standing fault stays visible
      output_overcurrent_flag <= oc_smp[0] | (oc_clr ? 4'h0 : output_overcurrent_flag);
    end else begin
      output_overcurrent_flag <= oc_smp[0];
    end
  end
  // ****************************************
  // composite error and interrupts
  // ****************************************
  assign composite_error = reserved_bits_error | (|range_counter_assign_error);
  assign ev = {|output_overcurrent_flag, composite_error & ~err_prev_reg, config_accepted, reserved_bits_error};
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      err_prev_reg <= 1'b0;
      irq_mask_reg <= 4'h0;
    end else begin
      err_prev_reg <= composite_error;
      if (wr_acc && pready && paddr == `CSV_OFF_IRQ_MASK) begin
        irq_mask_reg <= pwdata[3:0];
      end
    end
  end
  // read clears, but an event in the same cycle is kept
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_reg <= 4'h0;
    end else if (rd_acc && pready && paddr == `CSV_OFF_IRQ_STAT) begin
      irq_stat_reg <= ev;
    end else begin
      irq_stat_reg <= irq_stat_reg | ev;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end
  // ****************************************
  // read data
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= `CSV_ZERO32;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == `CSV_OFF_INSTATE) prdata <= {29'h0, phase_a_sample_bit};
      else if (paddr == `CSV_OFF_ECHO) prdata <= {28'h0, echo_reg};
      else if (paddr == `CSV_OFF_STATUS) prdata <= {20'h0, output_overcurrent_flag, range_counter_assign_error,
                                                    1'b0, composite_error, reserved_bits_error, config_accepted};
      else if (paddr == `CSV_OFF_CFG) prdata <= {29'h0, cfg_reg};
      else if (paddr == `CSV_OFF_OUTARR) prdata <= outarr_reg;
      else if (paddr == `CSV_OFF_RANGE) prdata <= {24'h0, range_setup_word};
      else if (paddr == `CSV_OFF_IRQ_STAT) prdata <= {28'h0, irq_stat_reg};
      else if (paddr == `CSV_OFF_IRQ_MASK) prdata <= {28'h0, irq_mask_reg};
      else if (paddr == `CSV_OFF_LATCH) prdata <= {31'h0, cfg_reg[`CSV_CFG_LATCH_BIT]};
      else prdata <= `CSV_ZERO32;
    end
  end
endmodule

/* File: csv_status_checker.sv */
`timescale 1ns/1ps
`include "csv_map.svh"
module csv_status_chk (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pins and commands
  input wire logic        phase_a_pin,
  input wire logic        phase_b_pin,
  input wire logic        index_pin,
  input wire logic [3:0]  counter_out_cmd,
  input wire logic [3:0]  counter_out_cmd_valid,
  input wire logic [3:0]  overcurrent_pin,
  input wire logic [3:0]  output_drive,
  input wire logic        irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [2:0] pins;
  logic [2:0] pin_q;
  logic [2:0] stab;
  assign pins = {index_pin, phase_b_pin, phase_a_pin};
  // pin reads are only judged once the sampler has had time to settle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_q <= 3'h0;
      stab  <= 3'h0;
    end else begin
      pin_q <= pins;
      stab  <= (pins != pin_q) ? 3'h0 : ((stab == 3'h7) ? stab : stab + 3'h1);
    end
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_bad_out;
    psel && penable && pready && pwrite && paddr == `CSV_OFF_OUTARR && pwdata[31:4] != 28'h000_0000 &&
    counter_out_cmd_valid == 4'h0;
  endsequence
  property p_rdy_after_setup;
    s_setup |=> pready;
  endproperty
  a_rdy_after_setup: assert property (p_rdy_after_setup) else $error("pready missing after setup");
  property p_rdy_single;
    pready |=> !pready;
  endproperty
  a_rdy_single: assert property (p_rdy_single) else $error("pready held too long");
  property p_err_rdy;
    pslverr |-> pready;
  endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("pslverr without pready");
  property p_unmapped;
    (psel && penable && pready && paddr > `CSV_OFF_LATCH) |-> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_echo;
    (|counter_out_cmd_valid) |=> ((output_drive ^ $past(counter_out_cmd)) & $past(counter_out_cmd_valid)) == 4'h0;
  endproperty
  a_echo: assert property (p_echo) else $error("counter command not driven");
  property p_reject;
    s_bad_out |=> $stable(output_drive);
  endproperty
  a_reject: assert property (p_reject) else $error("reserved array applied");
  property p_composite;
    (pready && !pwrite && paddr == `CSV_OFF_STATUS && (prdata[1] || prdata[7:4] != 4'h0)) |-> prdata[2];
  endproperty
  a_composite: assert property (p_composite) else $error("composite error missing");
  property p_instate;
    (pready && !pwrite && paddr == `CSV_OFF_INSTATE && stab == 3'h7) |-> prdata[2:0] == pins;
  endproperty
  a_instate: assert property (p_instate) else $error("input state stale");
endmodule
bind csv_status csv_status_chk u_chk (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .phase_a_pin(phase_a_pin), .phase_b_pin(phase_b_pin), .index_pin(index_pin), .counter_out_cmd(counter_out_cmd),
  .counter_out_cmd_valid(counter_out_cmd_valid), .overcurrent_pin(overcurrent_pin),
  .output_drive(output_drive), .irq(irq));

/* File: csv_ctrl_model.sv */
`timescale 1ns/1ps
module csv_ctrl_model (
  // clock
  input wire logic         core_clk,
  // apb master
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end
  // reserved output-array bits are only set where a caller means to be refused
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e, output logic to);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    to = (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

/* File: counter_status_validation_test.sv */
`timescale 1ns/1ps
`include "csv_map.svh"
module counter_status_validation_test;
  logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, er, to;
  logic phase_a_pin, phase_b_pin, index_pin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] counter_out_cmd, counter_out_cmd_valid, overcurrent_pin, output_drive;
  int errors, n_checks;
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  csv_status dut_u (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .phase_a_pin(phase_a_pin), .phase_b_pin(phase_b_pin), .index_pin(index_pin),
    .counter_out_cmd(counter_out_cmd), .counter_out_cmd_valid(counter_out_cmd_valid),
    .overcurrent_pin(overcurrent_pin), .output_drive(output_drive), .irq(irq));
  csv_ctrl_model ctl_u (.core_clk(core_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  task finish_test;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    ctl_u.xfer(w, a, d, rd, er, to);
    if (to) begin
      errors++;
      $display("ERROR pready expected 1 seen 0");
      finish_test();
    end
  endtask
  task rdc(input string nm, input logic [11:0] a, input logic [11:0] exp);
    acc(1'b0, a, 32'h0000_0000);
    chk(nm, exp, rd[11:0]);
  endtask
  task wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  initial begin
    {rst_n, phase_a_pin, phase_b_pin, index_pin} = 4'h0;
    {counter_out_cmd, counter_out_cmd_valid, overcurrent_pin} = 12'h000;
    wt(12);
    rst_n <= 1'b1;
    rdc("status", `CSV_OFF_STATUS, 12'h000);
    rdc("irq_mask", `CSV_OFF_IRQ_MASK, 12'h000);
    phase_a_pin <= 1'b1;
    index_pin <= 1'b1;
    wt(8);
    rdc("instate", `CSV_OFF_INSTATE, 12'h005);
    $display("test reset and pins done");
    // a zero counter count faults every range, so configure before the first array
    acc(1'b1, `CSV_OFF_CFG, 32'h0000_0002);
    acc(1'b1, `CSV_OFF_OUTARR, 32'h0000_0003);
    rdc("echo", `CSV_OFF_ECHO, 12'h003);
    // the counter logic drives bit 2 without any bus write
    counter_out_cmd <= 4'h4;
    counter_out_cmd_valid <= 4'h4;
    wt(1);
    counter_out_cmd_valid <= 4'h0;
    wt(2);
    rdc("echo_cnt", `CSV_OFF_ECHO, 12'h007);
    chk("drive", 12'h007, {8'h00, output_drive});
    acc(1'b1, `CSV_OFF_IRQ_MASK, 32'h0000_0004);
    acc(1'b1, `CSV_OFF_CFG, 32'h0000_0002);
    rdc("cfg_busy", `CSV_OFF_STATUS, 12'h000);
    wt(6);
    rdc("cfg_ok", `CSV_OFF_STATUS, 12'h001);
    $display("test echo and config done");
    // range 0 selects counter 3 while only two are configured
    acc(1'b1, `CSV_OFF_RANGE, 32'h0000_0003);
    acc(1'b1, `CSV_OFF_OUTARR, 32'h0000_0005);
    rdc("status_rng", `CSV_OFF_STATUS, 12'h015);
    rdc("echo_rng", `CSV_OFF_ECHO, 12'h007);
    chk("irq", 12'h001, {11'h000, irq});
    rdc("irq_stat", `CSV_OFF_IRQ_STAT, 12'h006);
    wt(2);
    chk("irq_clr", 12'h000, {11'h000, irq});
    acc(1'b1, `CSV_OFF_RANGE, 32'h0000_0000);
    acc(1'b1, `CSV_OFF_OUTARR, 32'h0000_0005);
    rdc("status_fix", `CSV_OFF_STATUS, 12'h001);
    rdc("echo_fix", `CSV_OFF_ECHO, 12'h005);
    acc(1'b1, `CSV_OFF_OUTARR, 32'h0000_0018);
    rdc("status_rsv", `CSV_OFF_STATUS, 12'h007);
    rdc("echo_rsv", `CSV_OFF_ECHO, 12'h005);
    acc(1'b1, `CSV_OFF_OUTARR, 32'h0000_0008);
    rdc("status_clean", `CSV_OFF_STATUS, 12'h001);
    rdc("echo_clean", `CSV_OFF_ECHO, 12'h008);
    $display("test array checks done");
    overcurrent_pin <= 4'h2;
    wt(8);
    acc(1'b0, `CSV_OFF_STATUS, 32'h0000_0000);
    chk("oc_live", 12'h002, {8'h00, rd[11:8]});
    overcurrent_pin <= 4'h0;
    wt(8);
    acc(1'b0, `CSV_OFF_STATUS, 32'h0000_0000);
    chk("oc_gone", 12'h000, {8'h00, rd[11:8]});
    acc(1'b1, `CSV_OFF_CFG, 32'h0000_0006);
    overcurrent_pin <= 4'h4;
    wt(8);
    overcurrent_pin <= 4'h0;
    wt(8);
    // the controller looks at the flags before clearing them
    acc(1'b0, `CSV_OFF_STATUS, 32'h0000_0000);
    chk("oc_held", 12'h004, {8'h00, rd[11:8]});
    acc(1'b1, `CSV_OFF_CTRL, 32'h0000_0001);
    acc(1'b0, `CSV_OFF_STATUS, 32'h0000_0000);
    chk("oc_clr", 12'h000, {8'h00, rd[11:8]});
    acc(1'b1, 12'h030, 32'hFFFF_FFFF);
    chk("slverr", 12'h001, {11'h000, er});
    $display("test overcurrent and refusal done");
    finish_test();
  end
endmodule
